/* hw/cbs_pkg.sv */
// Constants and state codes for the bus cycle sequencer
package cbs_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int BE_W = 2;
    // Double-rate clock period and processor clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROC_CLK_NS = 20;
    localparam int BUS_STATE_CLKS = PROC_CLK_NS / CLK_PERIOD_NS;
    // Least life of a strobed address, in processor clocks
    localparam int ADDR_STABLE_PROC_CLKS = 2;
    localparam int ADDR_STABLE_CLKS = ADDR_STABLE_PROC_CLKS * BUS_STATE_CLKS;
    localparam int BUF_DEPTH = 2;
    // Pin values while reset is held
    localparam logic [ADDR_W-1:0] RST_ADDR = 23'h7FFFFF;
    localparam logic [BE_W-1:0] RST_BYTE_EN_N = 2'h0;
    localparam logic RST_WRITE = 1'h0;
    localparam logic RST_DATA_CODE = 1'h1;
    localparam logic RST_MEM_IO = 1'h0;
    localparam logic RST_STROBE_N = 1'h1;
    localparam logic RST_HOLD_ACK = 1'h0;
    localparam logic RST_DATA_OE_N = 1'h1;

    typedef enum logic [6:0] {
        S_IDLE_STATE = 7'h01,
        S_FIRST_STATE = 7'h02,
        S_SECOND_STATE = 7'h04,
        S_PIPELINED_FIRST_STATE = 7'h08,
        S_SECOND_ADDR_DRIVEN = 7'h10,
        S_SECOND_ADDR_PENDING = 7'h20,
        S_HOLD_STATE = 7'h40
    } cbs_state_t;
endpackage : cbs_pkg

/* hw/cbs_phase.sv */
// Processor clock phase tracker on the double-rate clock
`timescale 1ns/10ps
module cbs_phase (
    input wire logic i_clk,    // Double-rate clock
    input wire logic i_reset,  // Synchronous reset, high
    output logic o_phase2      // High in phase two of a bus state
);
    logic phase2_reg;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase2_reg <= 1'b0;
        end else begin
            phase2_reg <= ~phase2_reg;
        end
    end

    assign o_phase2 = phase2_reg;
endmodule : cbs_phase

/* hw/cbs_buf.sv */
// Two-entry buffer for captured read data
`timescale 1ns/10ps
module cbs_buf #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,                // Clock
    input wire logic i_reset,              // Synchronous reset, high
    input wire logic i_in_valid,           // Push a word
    output logic o_in_ready,               // Room for a word
    input wire logic [WIDTH-1:0] i_in_data,// Word pushed
    output logic o_out_valid,              // Head word valid (flop)
    input wire logic i_out_ready,          // Drain side takes head
    output logic [WIDTH-1:0] o_out_data,   // Head word (flop)
    output logic [1:0] o_count             // Words held
);
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic valid_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = valid_reg && i_out_ready;

    assign o_in_ready = (count_reg != 2'h2);
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            valid_reg <= (count_next != 2'h0);
        end
    end

    // Head always sits in one flop so the output needs no read mux
    always_ff @(posedge i_clk) begin
        if (pop) begin
            head_reg <= (count_reg == 2'h2) ? tail_reg : i_in_data;
        end else if (push && count_reg == 2'h0) begin
            head_reg <= i_in_data;
        end
        if (push && (count_reg == 2'h2 || (count_reg == 2'h1 && !pop))) begin
            tail_reg <= i_in_data;
        end
    end

    assign o_out_valid = valid_reg;
    assign o_out_data = head_reg;
    assign o_count = count_reg;
endmodule : cbs_buf

/* hw/cbs_seq.sv */
// Bus cycle sequencer: states, address pipelining, wait states, data pins
// What this block and its far side do
// RL1: First cycle after idle is non-pipelined
// RL2: Ready sampled at second state end
// RL3: Negated ready adds wait states indefinitely
// RL4: Read acknowledge captures data pins
// RL5: Write data driven phase two to after-ack phase one
// RL6: First state drives address, definition, strobe together
// RL7: Data pins released during read cycles
// RL8: Far side holds valid data at acknowledge
// RL9: Address steady through non-pipelined wait states
// RL10: Far side negates next-address to avoid pipelining
// RL11: First state to second; unacked second repeats
// RL12: Acked second goes hold, first or idle
// RL13: Next-address sampled each phase one end (code samples only in second states and pipelined first)
// RL14: Next-address acts once per cycle
// RL15: Pending request issued next state after sampling
// RL16: No request gives pending, later driven state
// RL17: Far side trusts strobe, not next-address
// RL18: Strobed address stable two processor clocks
// RL19: Only one cycle ahead exposed
// RL20: Pipelined cycle starts in pipelined first state
// RL21: Four states non-pipelined; hold asserts acknowledge
// RL22: Far side gives one wait state to start pipelining
// RL23: Bus state lasts two clock periods
// RL24: Pipelining continues only from driven second state
// RL25: Reset gives idle, strobe negated, pins released
`timescale 1ns/10ps
module cbs_seq (
    input wire logic i_clk,                                 // Double-rate clock
    input wire logic i_reset,                               // Synchronous reset, high
    input wire logic i_req_valid,                           // Internal cycle request
    input wire logic i_req_write,                           // Request is a write
    input wire logic [cbs_pkg::ADDR_W-1:0] i_req_addr,      // Request address
    input wire logic [cbs_pkg::BE_W-1:0] i_req_byte_en_n,   // Request byte enables
    input wire logic i_req_data_code,                       // Request data/code
    input wire logic i_req_mem_io,                          // Request memory/io
    input wire logic [cbs_pkg::DATA_W-1:0] i_req_wdata,     // Request write data
    output logic o_req_taken,                               // Request consumed pulse
    output logic o_rd_valid,                                // Read word valid
    output logic [cbs_pkg::DATA_W-1:0] o_rd_data,           // Read word
    input wire logic i_rd_ready,                            // Read word taken
    output logic [cbs_pkg::ADDR_W-1:0] o_addr,              // Address pins
    output logic [cbs_pkg::BE_W-1:0] o_byte_en_n,           // Byte enable pins
    output logic o_write,                                   // Write/read pin
    output logic o_data_code,                               // Data/code pin
    output logic o_mem_io,                                  // Memory/io pin
    output logic o_address_strobe_n,                        // Address strobe, low
    input wire logic i_cycle_ready_n,                       // Cycle acknowledge, low
    input wire logic i_next_address_request_n,              // Next address, low
    input wire logic i_hold,                                // Hold request
    output logic o_hold_acknowledge,                        // Hold acknowledge
    input wire logic [cbs_pkg::DATA_W-1:0] i_data,          // Data pins in
    output logic [cbs_pkg::DATA_W-1:0] o_data,              // Data pins out
    output logic o_data_oe_n,                               // Data drive, low drives
    output logic [6:0] o_bus_state                          // Current bus state
);
    cbs_pkg::cbs_state_t state_reg;
    cbs_pkg::cbs_state_t state_next;
    logic phase2;
    logic next_seen_reg;
    logic post_ack_reg;
    logic cur_write_reg;
    logic [cbs_pkg::DATA_W-1:0] cur_wdata_reg;
    logic nxt_write_reg;
    logic [cbs_pkg::DATA_W-1:0] nxt_wdata_reg;
    logic [1:0] rd_out_reg;
    logic [1:0] buf_count;
    logic buf_in_ready;
    logic [cbs_pkg::ADDR_W-1:0] addr_reg;
    logic [cbs_pkg::BE_W-1:0] byte_en_n_reg;
    logic write_reg;
    logic data_code_reg;
    logic mem_io_reg;
    logic strobe_n_reg;
    logic hold_ack_reg;
    logic taken_reg;
    logic [cbs_pkg::DATA_W-1:0] data_reg;
    logic data_oe_n_reg;

    cbs_phase u_phase (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_phase2(phase2)
    );

    wire state_end = phase2;
    wire phase1_end = !phase2;
    wire in_second = (state_reg == cbs_pkg::S_SECOND_STATE)
        || (state_reg == cbs_pkg::S_SECOND_ADDR_PENDING)
        || (state_reg == cbs_pkg::S_SECOND_ADDR_DRIVEN);
    wire in_first = (state_reg == cbs_pkg::S_FIRST_STATE)
        || (state_reg == cbs_pkg::S_PIPELINED_FIRST_STATE);
    wire ack = state_end && in_second && !i_cycle_ready_n; // RL2
    // Address valid a whole state already in second states and pipelined first
    wire next_window = in_second || (state_reg == cbs_pkg::S_PIPELINED_FIRST_STATE); // RL13
    wire next_sample = phase1_end && next_window && !i_next_address_request_n
        && !next_seen_reg; // RL14
    // Reads are issued only with buffer room reserved, so capture never stalls
    wire [2:0] rd_room_used = {1'b0, buf_count} + {1'b0, rd_out_reg};
    wire pending = i_req_valid && (i_req_write || rd_room_used < 3'(cbs_pkg::BUF_DEPTH));
    wire capture = ack && !cur_write_reg; // RL4

    // Transition picked at the end of each bus state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            cbs_pkg::S_IDLE_STATE, cbs_pkg::S_HOLD_STATE: begin
                if (i_hold) begin
                    state_next = cbs_pkg::S_HOLD_STATE;
                end else if (pending) begin
                    state_next = cbs_pkg::S_FIRST_STATE; // RL1
                end else begin
                    state_next = cbs_pkg::S_IDLE_STATE;
                end
            end
            cbs_pkg::S_FIRST_STATE: begin
                state_next = cbs_pkg::S_SECOND_STATE; // RL11
            end
            cbs_pkg::S_PIPELINED_FIRST_STATE: begin
                if (next_seen_reg) begin
                    state_next = pending ? cbs_pkg::S_SECOND_ADDR_DRIVEN
                        : cbs_pkg::S_SECOND_ADDR_PENDING; // RL16
                end else begin
                    state_next = cbs_pkg::S_SECOND_STATE;
                end
            end
            cbs_pkg::S_SECOND_STATE, cbs_pkg::S_SECOND_ADDR_PENDING: begin
                if (!i_cycle_ready_n) begin
                    if (i_hold) begin
                        state_next = cbs_pkg::S_HOLD_STATE; // RL12
                    end else if (pending) begin
                        state_next = cbs_pkg::S_FIRST_STATE; // RL24
                    end else begin
                        state_next = cbs_pkg::S_IDLE_STATE; // RL12
                    end
                end else if (next_seen_reg) begin
                    state_next = pending ? cbs_pkg::S_SECOND_ADDR_DRIVEN
                        : cbs_pkg::S_SECOND_ADDR_PENDING; // RL15
                end else begin
                    state_next = cbs_pkg::S_SECOND_STATE; // RL3
                end
            end
            cbs_pkg::S_SECOND_ADDR_DRIVEN: begin
                // Next cycle already committed on the pins
                state_next = !i_cycle_ready_n ? cbs_pkg::S_PIPELINED_FIRST_STATE
                    : cbs_pkg::S_SECOND_ADDR_DRIVEN; // RL20
            end
        endcase
    end

    wire issue_first = state_end && (state_next == cbs_pkg::S_FIRST_STATE);
    wire issue_ahead = state_end && (state_next == cbs_pkg::S_SECOND_ADDR_DRIVEN)
        && (state_reg != cbs_pkg::S_SECOND_ADDR_DRIVEN); // RL19
    wire start_pipelined = state_end && (state_next == cbs_pkg::S_PIPELINED_FIRST_STATE);
    wire take = issue_first || issue_ahead;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= cbs_pkg::S_IDLE_STATE; // RL25
        end else if (state_end) begin
            state_reg <= state_next; // RL23
        end
    end

    // Sticky per cycle; a new first state starts a fresh cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            next_seen_reg <= 1'b0;
        end else if (state_end && (state_next == cbs_pkg::S_FIRST_STATE
            || start_pipelined || state_next == cbs_pkg::S_IDLE_STATE
            || state_next == cbs_pkg::S_HOLD_STATE)) begin
            next_seen_reg <= 1'b0;
        end else if (next_sample) begin
            next_seen_reg <= 1'b1; // RL14
        end
    end

    // Current and look-ahead cycle bookkeeping
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cur_write_reg <= 1'b0;
            nxt_write_reg <= 1'b0;
        end else begin
            if (issue_first) begin
                cur_write_reg <= i_req_write;
            end else if (start_pipelined) begin
                cur_write_reg <= nxt_write_reg;
            end
            if (issue_ahead) begin
                nxt_write_reg <= i_req_write;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (issue_first) begin
            cur_wdata_reg <= i_req_wdata;
        end else if (start_pipelined) begin
            cur_wdata_reg <= nxt_wdata_reg;
        end
        if (issue_ahead) begin
            nxt_wdata_reg <= i_req_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_out_reg <= 2'h0;
        end else begin
            rd_out_reg <= rd_out_reg + {1'b0, take && !i_req_write} - {1'b0, capture};
        end
    end

    // Address, definition and strobe pins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            addr_reg <= cbs_pkg::RST_ADDR;
            byte_en_n_reg <= cbs_pkg::RST_BYTE_EN_N;
            write_reg <= cbs_pkg::RST_WRITE;
            data_code_reg <= cbs_pkg::RST_DATA_CODE;
            mem_io_reg <= cbs_pkg::RST_MEM_IO;
            strobe_n_reg <= cbs_pkg::RST_STROBE_N; // RL25
        end else if (take) begin // RL9
            addr_reg <= i_req_addr; // RL6
            byte_en_n_reg <= i_req_byte_en_n;
            write_reg <= i_req_write;
            data_code_reg <= i_req_data_code;
            mem_io_reg <= i_req_mem_io;
            strobe_n_reg <= 1'b0; // RL6
        end else if (state_end) begin
            strobe_n_reg <= 1'b1; // RL18
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            hold_ack_reg <= cbs_pkg::RST_HOLD_ACK;
            taken_reg <= 1'b0;
            post_ack_reg <= 1'b0;
        end else begin
            if (state_end) begin
                hold_ack_reg <= (state_next == cbs_pkg::S_HOLD_STATE); // RL21
            end
            taken_reg <= take;
            post_ack_reg <= ack && cur_write_reg;
        end
    end

    // Write data from phase two of the first state; held one phase past ack
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            data_oe_n_reg <= cbs_pkg::RST_DATA_OE_N; // RL25
            data_reg <= '0;
        end else if (phase1_end && in_first) begin
            data_oe_n_reg <= !cur_write_reg; // RL7
            data_reg <= cur_wdata_reg; // RL5
        end else if (phase1_end && post_ack_reg) begin
            data_oe_n_reg <= 1'b1; // RL5
        end
    end

    cbs_buf #(
        .WIDTH(cbs_pkg::DATA_W)
    ) u_buf (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(capture),
        .o_in_ready(buf_in_ready),
        .i_in_data(i_data),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data),
        .o_count(buf_count)
    );

    assign o_req_taken = taken_reg;
    assign o_addr = addr_reg;
    assign o_byte_en_n = byte_en_n_reg;
    assign o_write = write_reg;
    assign o_data_code = data_code_reg;
    assign o_mem_io = mem_io_reg;
    assign o_address_strobe_n = strobe_n_reg;
    assign o_hold_acknowledge = hold_ack_reg;
    assign o_data = data_reg;
    assign o_data_oe_n = data_oe_n_reg;
    assign o_bus_state = state_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_idle_first: assert property ( // RL1
        state_reg == cbs_pkg::S_IDLE_STATE |=> state_reg != cbs_pkg::S_PIPELINED_FIRST_STATE)
        else $error("pipelined first state entered from idle");
    chk_ready_ends: assert property ( // RL2
        state_end && state_reg == cbs_pkg::S_SECOND_STATE && !i_cycle_ready_n
        |=> state_reg inside {cbs_pkg::S_FIRST_STATE, cbs_pkg::S_IDLE_STATE,
            cbs_pkg::S_HOLD_STATE})
        else $error("acknowledged second state did not end the cycle");
    chk_wait_repeat: assert property ( // RL3
        state_end && state_reg == cbs_pkg::S_SECOND_STATE && i_cycle_ready_n && !next_seen_reg
        |=> state_reg == cbs_pkg::S_SECOND_STATE)
        else $error("wait state not inserted");
    chk_first_second: assert property ( // RL11
        state_end && state_reg == cbs_pkg::S_FIRST_STATE |=> state_reg == cbs_pkg::S_SECOND_STATE)
        else $error("first state not followed by second state");
    chk_strobe_start: assert property ( // RL6
        $rose(state_reg == cbs_pkg::S_FIRST_STATE) |-> !o_address_strobe_n ##2 o_address_strobe_n)
        else $error("strobe not one bus state at first state");
    chk_addr_stable: assert property ( // RL18
        $fell(o_address_strobe_n) |=> $stable(o_addr) [*3])
        else $error("strobed address changed within two processor clocks");
    chk_read_float: assert property ( // RL7
        in_second && !cur_write_reg && !post_ack_reg |-> o_data_oe_n)
        else $error("data pins driven in a read cycle");
    chk_write_hold: assert property ( // RL5
        ack && cur_write_reg |=> !o_data_oe_n && o_data == $past(cur_wdata_reg))
        else $error("write data dropped before hold phase");
    chk_capture_room: assert property ( // RL4
        capture |-> buf_in_ready)
        else $error("read data captured with no buffer room");
    chk_driven_stays: assert property ( // RL14
        state_end && state_reg == cbs_pkg::S_SECOND_ADDR_DRIVEN && i_cycle_ready_n
        |=> state_reg == cbs_pkg::S_SECOND_ADDR_DRIVEN && o_address_strobe_n)
        else $error("driven second state left or restrobed without acknowledge");
    chk_pending_ends: assert property ( // RL24
        ack && state_reg == cbs_pkg::S_SECOND_ADDR_PENDING
        |=> state_reg != cbs_pkg::S_PIPELINED_FIRST_STATE)
        else $error("pipelining continued from pending second state");
    chk_hold_ack: assert property ( // RL21
        (state_reg == cbs_pkg::S_HOLD_STATE) == o_hold_acknowledge)
        else $error("hold acknowledge disagrees with hold state");
    chk_state_len: assert property ( // RL23
        $changed(state_reg) |=> $stable(state_reg))
        else $error("bus state shorter than two clocks");

    cov_wait_state: cover property (
        state_end && state_reg == cbs_pkg::S_SECOND_STATE && i_cycle_ready_n);
    cov_pipelined: cover property (
        state_reg == cbs_pkg::S_SECOND_ADDR_DRIVEN
        ##2 state_reg == cbs_pkg::S_PIPELINED_FIRST_STATE);
    cov_pending: cover property (state_reg == cbs_pkg::S_SECOND_ADDR_PENDING);
    cov_hold: cover property (state_reg == cbs_pkg::S_HOLD_STATE);
endmodule : cbs_seq

/* testbench/cbs_far_end.sv */
// Far-side decode and acknowledge model for the bus cycle sequencer
`timescale 1ns/10ps
module cbs_far_end (
    input wire logic i_clk,                           // Clock
    input wire logic i_reset,                         // Sync reset, high
    input wire logic [6:0] i_state,                   // Sequencer state
    input wire logic i_strobe_n,                      // Address strobe, low
    input wire logic i_write,                         // Write/read pin
    input wire logic [cbs_pkg::ADDR_W-1:0] i_addr,    // Address pins
    input wire logic [3:0] i_waits,                   // Wait states wanted
    input wire logic i_pipe_on,                       // Ask for pipelining
    output logic o_ready_n,                           // Acknowledge, low
    output logic o_next_n,                            // Next address, low
    output logic o_cur_wr,                            // Current cycle writes
    output logic [cbs_pkg::DATA_W-1:0] o_data         // Data pins driven
);
    logic [23:0] cyc_q[$];
    logic [23:0] hd_reg;
    logic have_reg;
    logic [4:0] cnt_reg;
    logic strobe_reg;
    logic [15:0] last_reg;
    logic second;
    assign second = i_state inside {7'h04, 7'h10, 7'h20};
    // Ack only on a state-end clock, after the chosen wait states
    assign o_ready_n = !(second && have_reg && cnt_reg >= 5'(2 * i_waits + 1));
    assign o_next_n = !(i_pipe_on && (second || i_state == 7'h08));
    assign o_cur_wr = hd_reg[23];
    // Released lines toggle so a stale capture cannot pass
    assign o_data = (!o_ready_n && !hd_reg[23]) ? ~hd_reg[15:0] : ~last_reg;
    always @(posedge i_clk) begin
        if (i_reset) begin
            cyc_q.delete();
            cnt_reg <= 5'h00;
            strobe_reg <= 1'b1;
        end else begin
            cnt_reg <= second ? cnt_reg + 5'h01 : 5'h00;
            strobe_reg <= i_strobe_n;
            if (!o_ready_n) cyc_q.pop_front();
            // Strobe, not next-address, marks a new cycle
            if (!i_strobe_n && strobe_reg) cyc_q.push_back({i_write, i_addr});
        end
        last_reg <= i_reset ? 16'h0000 : o_data;
        have_reg <= !i_reset && cyc_q.size() != 0;
        if (cyc_q.size() != 0) hd_reg <= cyc_q[0];
    end
endmodule : cbs_far_end

/* testbench/test_cbs_seq.sv */
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module test_cbs_seq;
    logic i_clk = 0, i_reset = 1, i_req_valid = 0, i_req_write = 0, i_rd_ready = 0, i_hold = 0;
    logic [22:0] i_req_addr = 0, o_addr;
    logic [1:0] i_req_byte_en_n = 0, o_byte_en_n;
    logic i_req_data_code = 0, i_req_mem_io = 0, o_req_taken, o_rd_valid, o_write;
    logic o_data_code, o_mem_io, o_address_strobe_n, o_hold_acknowledge, o_data_oe_n;
    logic [15:0] i_req_wdata = 0, o_rd_data, o_data, far_data, bus_data;
    logic [6:0] o_bus_state;
    logic ready_n, next_n, cur_wr, pipe_on = 0, stall = 0, saw_drv = 0, saw_pend = 0;
    logic [15:0] rnd = 16'h0057, rr = 16'h0057;
    logic [15:0] rdq[$], wrq[$];
    logic [3:0] waits = 0;
    int miscompares = 0, checks_done = 0, cycles = 0, waited;
    assign bus_data = o_data_oe_n ? far_data : o_data;
    cbs_seq dut (.i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
        .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_byte_en_n(i_req_byte_en_n),
        .i_req_data_code(i_req_data_code), .i_req_mem_io(i_req_mem_io),
        .i_req_wdata(i_req_wdata), .o_req_taken(o_req_taken), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_addr(o_addr),
        .o_byte_en_n(o_byte_en_n), .o_write(o_write), .o_data_code(o_data_code),
        .o_mem_io(o_mem_io), .o_address_strobe_n(o_address_strobe_n),
        .i_cycle_ready_n(ready_n), .i_next_address_request_n(next_n), .i_hold(i_hold),
        .o_hold_acknowledge(o_hold_acknowledge), .i_data(bus_data), .o_data(o_data),
        .o_data_oe_n(o_data_oe_n), .o_bus_state(o_bus_state));
    cbs_far_end far (.i_clk(i_clk), .i_reset(i_reset), .i_state(o_bus_state),
        .i_strobe_n(o_address_strobe_n), .i_write(o_write), .i_addr(o_addr), .i_waits(waits),
        .i_pipe_on(pipe_on), .o_ready_n(ready_n), .o_next_n(next_n), .o_cur_wr(cur_wr),
        .o_data(far_data));
    always #5 i_clk = ~i_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic issue(input logic wr);
        rnd = lfsr(rnd);
        i_req_valid = 1;
        i_req_write = wr;
        i_req_addr = {rnd[6:0], rnd};
        {i_req_mem_io, i_req_data_code, i_req_byte_en_n} = rnd[3:0];
        i_req_wdata = ~rnd;
        waited = 0;
        do begin
            @(negedge i_clk);
            waited++;
        end while (o_req_taken !== 1'b1 && waited < 300);
        `CHK(o_address_strobe_n, 1'b0)
        `CHK(o_addr, i_req_addr)
        `CHK({o_write, o_mem_io, o_data_code}, {wr, i_req_mem_io, i_req_data_code})
        `CHK(o_byte_en_n, i_req_byte_en_n)
        if (wr) wrq.push_back(i_req_wdata);
        else rdq.push_back(~i_req_addr[15:0]);
    endtask : issue
    task automatic run(input int n, input logic [1:0] kind);
        for (int i = 0; i < n; i++) issue(kind[1] ? rnd[4] : kind[0]);
        i_req_valid = 0;
    endtask : run
    task automatic drain(input string name);
        int k;
        k = 0;
        while ((rdq.size() + wrq.size() != 0 || o_bus_state !== 7'h01) && k < 500) begin
            @(negedge i_clk);
            k++;
        end
        `CHK(rdq.size() + wrq.size(), 0)
        $display("%s done", name);
    endtask : drain
    always @(negedge i_clk) begin
        rr <= lfsr(rr);
        i_rd_ready <= !stall && rr[0];
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
        if (o_bus_state === 7'h10) saw_drv <= 1;
        if (o_bus_state === 7'h20) saw_pend <= 1;
        if (o_rd_valid === 1'b1 && i_rd_ready) `CHK(o_rd_data, rdq.pop_front())
        if (ready_n === 1'b0) begin
            `CHK(o_data_oe_n, !cur_wr)
            // Outside the driven state the pins still hold the strobed address
            if (o_bus_state !== 7'h10) `CHK(o_addr, far.hd_reg[22:0])
            if (cur_wr) `CHK(o_data, wrq.pop_front())
        end
    end
    initial begin
        repeat (20) @(negedge i_clk);
        `CHK(o_bus_state, 7'h01)
        `CHK({o_address_strobe_n, o_data_oe_n, o_hold_acknowledge}, 3'h6)
        i_reset = 0;
        $display("reset done");
        pipe_on = 1;
        run(6, 2'h2);
        drain("no-wait mix");
        `CHK(saw_drv, 1'b0)
        pipe_on = 0;
        waits = 3;
        run(5, 2'h2);
        drain("wait states");
        `CHK(saw_drv, 1'b0)
        pipe_on = 1;
        waits = 1;
        run(10, 2'h2);
        drain("pipelined");
        `CHK(saw_drv, 1'b1)
        waits = 2;
        run(1, 2'h0);
        drain("pending");
        `CHK(saw_pend, 1'b1)
        pipe_on = 0;
        waits = 0;
        stall = 1;
        run(2, 2'h0);
        fork
            begin
                repeat (30) @(negedge i_clk);
                stall = 0;
            end
        join_none
        run(1, 2'h0);
        `CHK(waited >= 30, 1'b1)
        drain("buffer full");
        i_hold = 1;
        repeat (20) if (o_hold_acknowledge !== 1'b1) @(negedge i_clk);
        `CHK(o_bus_state, 7'h40)
        fork
            begin
                repeat (10) @(negedge i_clk);
                i_hold = 0;
            end
        join_none
        run(1, 2'h1);
        `CHK(waited >= 10, 1'b1)
        waits = 3;
        // Read taken at the write's ack; hold raised while the read waits
        run(1, 2'h0);
        i_hold = 1;
        repeat (40) if (o_hold_acknowledge !== 1'b1) @(negedge i_clk);
        `CHK(o_bus_state, 7'h40)
        i_hold = 0;
        drain("hold");
        summarize();
    end
endmodule : test_cbs_seq
